// ---- logic/css_pkg.sv ----
// Constants, register map and types for the clocked serial unit
package css_pkg;
	localparam int ADDR_W = 5;
	localparam int CHAR_BITS = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// Word offsets on the register bus
	localparam logic [ADDR_W-1:0] OFF_MODE = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_TXH = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_RXH = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_DIV = 5'h14;
	localparam logic [ADDR_W-1:0] WORD_MASK = 5'h1C;
	// serial_mode_reg fields
	localparam int MODE_SYNC = 0;
	// serial_control_reg fields
	localparam int CTRL_CKS0 = 0;
	localparam int CTRL_CKS1 = 1;
	localparam int CTRL_RXEN = 4;
	localparam int CTRL_TXEN = 5;
	localparam int CTRL_TX_END_IRQ_EN = 2;
	localparam int CTRL_RIE = 6;
	localparam int CTRL_TIE = 7;
	// serial_status_reg fields
	localparam int STAT_TXE = 7;
	localparam int STAT_RXF = 6;
	localparam int STAT_OVR = 5;
	localparam int STAT_FRM = 4;
	localparam int STAT_PAR = 3;
	localparam int STAT_TX_END_FLAG = 2;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0004;
	localparam logic TXE_RST = 1'b1;
	localparam logic TX_END_FLAG_RST = 1'b1;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {CSS_IDLE, CSS_RUN} css_frame_e;
endpackage

// ---- logic/css_sync_serial.sv ----
// Clocked serial unit, synchronous mode, with an AXI4-Lite register port
`timescale 1ns/1ns
module css_sync_serial #(
	parameter int DIV_W = 16
)(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [css_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [css_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_n_out,
	input wire logic rxd_in,
	output logic txd_out,
	output logic tx_empty_irq_out,
	output logic tx_end_irq_out,
	output logic rx_full_irq_out,
	output logic rx_error_irq_out
);
	import css_pkg::*;

	logic [7:0] serial_mode_reg_r;
	logic [7:0] serial_control_reg_r;
	logic [DIV_W-1:0] div_r;
	logic tx_empty_flag_r, tx_end_flag_r, rx_full_flag_r;
	logic overrun_flag_r, framing_flag_r, parity_flag_r;
	logic [7:0] tx_holding_reg_r, tx_shift_reg_r;
	logic [7:0] rx_holding_reg_r, rx_shift_reg_r;
	logic txd_r;
	css_frame_e state_r;
	logic [2:0] bit_cnt_r;
	logic tx_run_r, rx_run_r, tx_more_r;
	logic sck_int_r;
	logic [DIV_W-1:0] half_cnt_r;
	logic sck_s1_r, sck_s2_r, sck_s3_r, rxd_s1_r, rxd_s2_r;
	logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;

	// Bus decode
	wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
	wire [ADDR_W-1:0] wa = awaddr_r & WORD_MASK;
	wire [ADDR_W-1:0] ra = s_axi_araddr_in & WORD_MASK;
	wire wr_lo = wr_fire & wstrb_r[0];
	wire wr_mode = wr_lo & (wa == OFF_MODE);
	wire wr_ctrl = wr_lo & (wa == OFF_CTRL);
	wire wr_stat = wr_lo & (wa == OFF_STAT);
	wire wr_txh = wr_lo & (wa == OFF_TXH);
	wire wr_div = wr_fire & (wa == OFF_DIV);
	wire wr_map = (wa == OFF_MODE) | (wa == OFF_CTRL) | (wa == OFF_STAT) |
		(wa == OFF_TXH) | (wa == OFF_RXH) | (wa == OFF_DIV);
	wire rd_take = s_axi_arvalid_in & ~rvalid_r;
	wire rd_rxh = rd_take & (ra == OFF_RXH);
	wire [7:0] stat_val = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r,
		framing_flag_r, parity_flag_r, tx_end_flag_r, 2'h0};
	wire rd_map = (ra == OFF_MODE) | (ra == OFF_CTRL) | (ra == OFF_STAT) |
		(ra == OFF_TXH) | (ra == OFF_RXH) | (ra == OFF_DIV);
	wire [31:0] rd_val =
		(ra == OFF_MODE) ? {24'h0, serial_mode_reg_r} :
		(ra == OFF_CTRL) ? {24'h0, serial_control_reg_r} :
		(ra == OFF_STAT) ? {24'h0, stat_val} :
		(ra == OFF_TXH) ? {24'h0, tx_holding_reg_r} :
		(ra == OFF_RXH) ? {24'h0, rx_holding_reg_r} :
		(ra == OFF_DIV) ? 32'(div_r) : 32'h0;

	// Control decode
	wire sync_mode_select = serial_mode_reg_r[MODE_SYNC];
	wire clock_src_bit1 = serial_control_reg_r[CTRL_CKS1];
	wire tx_enable = serial_control_reg_r[CTRL_TXEN];
	wire rx_enable = serial_control_reg_r[CTRL_RXEN];
	wire ext_clk = clock_src_bit1;
	wire err_any = overrun_flag_r | framing_flag_r | parity_flag_r;
	wire tx_go = sync_mode_select & tx_enable & ~tx_empty_flag_r &
		~err_any;
	wire rx_go = sync_mode_select & rx_enable & ~err_any;
	wire idle = (state_r == CSS_IDLE);
	wire run = (state_r == CSS_RUN);
	wire start = idle & (tx_go | rx_go);
	wire abort = run & (~sync_mode_select | (~tx_enable & ~rx_enable));

	// Serial clock events from the own generator or the far end
	wire [DIV_W-1:0] div_m1 = (div_r == '0) ? '0 : div_r - 1'b1;
	wire half_end = run & ~ext_clk & (half_cnt_r >= div_m1);
	wire ext_fall = ext_clk & sck_s3_r & ~sck_s2_r;
	wire ext_rise = ext_clk & ~sck_s3_r & sck_s2_r;
	wire fall_ev = run & ~abort & (ext_fall | (half_end & sck_int_r));
	wire rise_ev = run & ~abort & (ext_rise | (half_end & ~sck_int_r));
	wire last_fall = fall_ev & (bit_cnt_r == LAST_BIT);
	wire last_rise = rise_ev & (bit_cnt_r == LAST_BIT);
	wire tx_reload = last_fall & tx_run_r & tx_go;
	wire tx_load = (start & tx_go) | tx_reload;
	wire [7:0] rx_shift_nxt = {rxd_s2_r, rx_shift_reg_r[7:1]};
	wire rx_done = last_rise & rx_run_r;
	wire rx_store = rx_done & ~rx_full_flag_r;
	wire rx_ovr = rx_done & rx_full_flag_r;
	wire rx_cont = rx_go & ~rx_ovr;
	wire frame_cont = tx_more_r | rx_cont;

	// Bus slave: address and data are taken in either order
	assign s_axi_awready_out = ~aw_held_r;
	assign s_axi_wready_out = ~w_held_r;
	assign s_axi_arready_out = ~rvalid_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rdata_out = rdata_r;
	assign s_axi_rresp_out = rresp_r;

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
		end
		else if (s_axi_awvalid_in & ~aw_held_r)
		begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr_in;
		end
		else if (wr_fire)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			w_held_r <= 1'b0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end
		else if (s_axi_wvalid_in & ~w_held_r)
		begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata_in;
			wstrb_r <= s_axi_wstrb_in;
		end
		else if (wr_fire)
			w_held_r <= 1'b0;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready_in)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end
		else if (rd_take)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready_in)
			rvalid_r <= 1'b0;
	end

	// Software registers; reserved byte lanes ignored
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			serial_mode_reg_r <= MODE_RST;
			serial_control_reg_r <= CTRL_RST;
			div_r <= DIV_W'(DIV_RST);
			tx_holding_reg_r <= 8'h00;
		end
		else
		begin
			if (wr_mode)
				serial_mode_reg_r <= wdata_r[7:0];
			if (wr_ctrl)
				serial_control_reg_r <= wdata_r[7:0];
			if (wr_div & wstrb_r[0] & wstrb_r[1])
				div_r <= wdata_r[DIV_W-1:0];
			if (wr_txh)
				tx_holding_reg_r <= wdata_r[7:0];
		end
	end

	// Flags: a hardware set beats a clear in the same cycle
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			tx_empty_flag_r <= TXE_RST;
			tx_end_flag_r <= TX_END_FLAG_RST;
		end
		else
		begin
			if (tx_load | ~tx_enable)
				tx_empty_flag_r <= 1'b1;
			else if (wr_txh)
				tx_empty_flag_r <= 1'b0;
			if (last_fall & tx_run_r & ~tx_go)
				tx_end_flag_r <= 1'b1;
			else if (tx_load)
				tx_end_flag_r <= 1'b0;
		end
	end

	// Clearing rx_enable touches none of these
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			rx_full_flag_r <= 1'b0;
			overrun_flag_r <= 1'b0;
			framing_flag_r <= 1'b0;
			parity_flag_r <= 1'b0;
			rx_holding_reg_r <= 8'h00;
		end
		else
		begin
			if (rx_store)
				rx_full_flag_r <= 1'b1;
			else if (rd_rxh | (wr_stat & ~wdata_r[STAT_RXF]))
				rx_full_flag_r <= 1'b0;
			if (rx_ovr)
				overrun_flag_r <= 1'b1;
			else if (wr_stat & ~wdata_r[STAT_OVR])
				overrun_flag_r <= 1'b0;
			// Never set in this mode; kept for software compatibility
			if (wr_stat & ~wdata_r[STAT_FRM])
				framing_flag_r <= 1'b0;
			if (wr_stat & ~wdata_r[STAT_PAR])
				parity_flag_r <= 1'b0;
			if (rx_store)
				rx_holding_reg_r <= rx_shift_nxt;
		end
	end

	// Pin synchronisers
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			sck_s1_r <= 1'b1;
			sck_s2_r <= 1'b1;
			sck_s3_r <= 1'b1;
			rxd_s1_r <= 1'b1;
			rxd_s2_r <= 1'b1;
		end
		else
		begin
			sck_s1_r <= serial_clock_pin_in;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			rxd_s1_r <= rxd_in;
			rxd_s2_r <= rxd_s1_r;
		end
	end

	// Internal clock generator; parks high between frames
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in | ~run | abort | ext_clk)
		begin
			sck_int_r <= 1'b1;
			half_cnt_r <= '0;
		end
		else if (half_end)
		begin
			sck_int_r <= ~sck_int_r;
			half_cnt_r <= '0;
		end
		else
			half_cnt_r <= half_cnt_r + 1'b1;
	end

	// Frame sequencer
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			state_r <= CSS_IDLE;
			bit_cnt_r <= 3'h0;
			tx_run_r <= 1'b0;
			rx_run_r <= 1'b0;
			tx_more_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				CSS_IDLE:
				begin
					if (start)
					begin
						state_r <= CSS_RUN;
						bit_cnt_r <= 3'h0;
						tx_run_r <= tx_go;
						rx_run_r <= rx_go;
						tx_more_r <= 1'b0;
					end
				end
				CSS_RUN:
				begin
					if (abort)
						state_r <= CSS_IDLE;
					else if (last_rise)
					begin
						state_r <= frame_cont ? CSS_RUN : CSS_IDLE;
						bit_cnt_r <= 3'h0;
						tx_run_r <= tx_more_r;
						rx_run_r <= rx_cont;
						tx_more_r <= 1'b0;
					end
					else
					begin
						if (rise_ev)
							bit_cnt_r <= bit_cnt_r + 1'b1;
						if (tx_reload)
							tx_more_r <= 1'b1;
					end
				end
				default:
					state_r <= CSS_IDLE;
			endcase
		end
	end

	// Shifters
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			tx_shift_reg_r <= 8'h00;
			rx_shift_reg_r <= 8'h00;
			txd_r <= 1'b1;
		end
		else
		begin
			if (tx_load)
				tx_shift_reg_r <= tx_holding_reg_r;
			else if (fall_ev & tx_run_r)
				tx_shift_reg_r <= {1'b0, tx_shift_reg_r[7:1]};
			if (fall_ev & tx_run_r)
				txd_r <= tx_shift_reg_r[0];
			if (rise_ev & rx_run_r)
				rx_shift_reg_r <= rx_shift_nxt;
		end
	end

	assign txd_out = txd_r;
	assign serial_clock_pin_out = sck_int_r;
	assign serial_clock_pin_oe_n_out = ~(sync_mode_select & ~ext_clk);
	assign tx_empty_irq_out = tx_empty_flag_r &
		serial_control_reg_r[CTRL_TIE];
	assign tx_end_irq_out = tx_end_flag_r & serial_control_reg_r[CTRL_TX_END_IRQ_EN];
	assign rx_full_irq_out = rx_full_flag_r & serial_control_reg_r[CTRL_RIE];
	assign rx_error_irq_out = err_any & serial_control_reg_r[CTRL_RIE];

	// Checks
	logic [3:0] fall_cnt_r;
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in | start | last_rise)
			fall_cnt_r <= 4'h0;
		else if (fall_ev)
			fall_cnt_r <= fall_cnt_r + 1'b1;
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_txh_write;
		wr_txh & ~tx_load & tx_enable;
	endsequence
	sequence s_rxh_read;
		rd_rxh & ~rx_store;
	endsequence

	a_tx_off_empty: assert property (
		~tx_enable |=> tx_empty_flag_r)
		else $error("tx_empty_flag not set with transmit disabled");
	a_rx_off_keeps: assert property (
		wr_ctrl & ~wdata_r[CTRL_RXEN] & ~rd_rxh & ~rx_done & ~wr_stat
		|=> $stable(rx_holding_reg_r) & $stable(rx_full_flag_r) &
		$stable(overrun_flag_r))
		else $error("receive state changed by disabling receive");
	a_tx_load_start: assert property (
		tx_load |=> tx_empty_flag_r &
		(tx_shift_reg_r == $past(tx_holding_reg_r)))
		else $error("transmit load did not take holding data");
	a_tx_end_set: assert property (
		last_fall & tx_run_r & ~tx_go |=> tx_end_flag_r & ~tx_more_r)
		else $error("transmit end not flagged");
	a_no_err_start: assert property (
		err_any |-> ~tx_load)
		else $error("transmission started with an error flag");
	a_rx_store_data: assert property (
		rx_store |=> rx_full_flag_r &
		(rx_holding_reg_r == rx_shift_reg_r))
		else $error("received character not stored");
	a_overrun_hold: assert property (
		rx_ovr |=> overrun_flag_r & rx_full_flag_r &
		$stable(rx_holding_reg_r))
		else $error("overrun handling wrong");
	a_txh_clears: assert property (
		s_txh_write |=> ~tx_empty_flag_r)
		else $error("transmit holding write left empty flag set");
	a_rxh_clears: assert property (
		s_rxh_read |=> ~rx_full_flag_r)
		else $error("receive holding read left full flag set");
	a_eight_falls: assert property (
		last_rise |-> fall_cnt_r == 4'h8)
		else $error("frame did not carry eight clock pulses");
	a_clk_idle_high: assert property (
		idle ##1 idle |-> sck_int_r)
		else $error("serial clock not high while idle");
	a_txd_on_fall: assert property (
		$changed(txd_r) |-> $past(fall_ev))
		else $error("transmit data changed off a falling edge");
endmodule

// ---- verification/css_peer.sv ----
// Behavioural clocked serial peer facing the serial unit's link pins
`timescale 1ns/1ns
module css_peer (
	input wire logic sclk_in,
	output logic sclk_out,
	input wire logic txd_in,
	output logic rxd_out
);
	logic [7:0] send_q[$];
	logic [7:0] got_q[$];
	logic [7:0] cur_r;
	logic [7:0] cap_r;
	int n_tx_bit = 0;
	int n_rx_bit = 0;
	int n_rise = 0;
	int max_gap = 0;
	longint last_rise = 0;
	initial
	begin
		sclk_out = 1'b1; // No pulses until a frame is asked for
		rxd_out = 1'b1;
		cur_r = 8'hFF;
		cap_r = 8'h00;
	end
	// Empty queue sends the inverse of the last bit, never a stale copy
	always @(negedge sclk_in)
	begin
		if (n_tx_bit == 0)
			cur_r = (send_q.size() > 0) ? send_q.pop_front() : {8{~rxd_out}};
		rxd_out = cur_r[n_tx_bit];
		n_tx_bit = (n_tx_bit + 1) % 8;
	end
	// Gaps of 1 us or more belong to separate bursts and are not measured
	always @(posedge sclk_in)
	begin
		cap_r = {txd_in, cap_r[7:1]};
		if ($time - last_rise < 1000 && $time - last_rise > max_gap)
			max_gap = $time - last_rise;
		last_rise = $time;
		n_rise++;
		n_rx_bit++;
		if (n_rx_bit == 8)
		begin
			got_q.push_back(cap_r);
			n_rx_bit = 0;
		end
	end
	task automatic load(input logic [7:0] b);
		send_q.push_back(b);
	endtask
	task automatic clear();
		n_rise = 0;
		max_gap = 0;
		n_tx_bit = 0;
		n_rx_bit = 0;
		got_q.delete();
	endtask
	// Eight pulses at a 400 ns period, clock left high afterwards
	task automatic ext_frame();
		#13; // Keep pin edges off the reference clock edges
		repeat (8)
		begin
			#200 sclk_out = 1'b0;
			#200 sclk_out = 1'b1;
		end
	endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the clocked serial unit
`timescale 1ns/1ns
module testbench;
	import css_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] awaddr = 5'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic [3:0] wstrb = 4'hF;
	logic bready = 1'b0;
	logic rready = 1'b0;
	logic [1:0] wresp;
	logic [ADDR_W-1:0] araddr = 5'h00;
	logic arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic sclk_dut, sclk_oe_n, sclk_peer, sclk_wire, rxd, txd;
	logic irq_te, irq_tx_end_flag, irq_rf, irq_re;
	logic [31:0] d;
	int n_errors = 0;
	int checked = 0;
	int snap;
	assign sclk_wire = sclk_oe_n ? sclk_peer : sclk_dut;
	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end
	css_sync_serial #(.DIV_W(16)) u_dut (
		.ref_clk_in(ref_clk), .reset_in(reset),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .serial_clock_pin_in(sclk_wire),
		.serial_clock_pin_out(sclk_dut),
		.serial_clock_pin_oe_n_out(sclk_oe_n), .rxd_in(rxd),
		.txd_out(txd), .tx_empty_irq_out(irq_te),
		.tx_end_irq_out(irq_tx_end_flag), .rx_full_irq_out(irq_rf),
		.rx_error_irq_out(irq_re)
	);
	css_peer u_peer (
		.sclk_in(sclk_wire), .sclk_out(sclk_peer),
		.txd_in(txd), .rxd_out(rxd)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h, wanted %h",
				$time, seen, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge ref_clk);
			if (!aw_done && awready === 1'b1)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		@(posedge ref_clk);
		while (bvalid !== 1'b1)
			@(posedge ref_clk);
		wresp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge ref_clk);
		while (arready !== 1'b1)
			@(posedge ref_clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		@(posedge ref_clk);
		while (rvalid !== 1'b1)
			@(posedge ref_clk);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [1:0] r;
		rd(a, d, r);
		check(d & m, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		n_errors++;
		$display("CHECK FAILED at %0t: run timed out", $time);
		finish_test();
	end
	initial
	begin
		logic [1:0] r;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rchk(OFF_STAT, ALL, 32'h84);
		rchk(OFF_CTRL, ALL, 32'h0);
		rchk(OFF_DIV, ALL, 32'h4);
		rd(5'h18, d, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		check(d, 32'h0);
		wstrb <= 4'hE;
		wr(OFF_MODE, 32'h1);
		wstrb <= 4'hF;
		rchk(OFF_MODE, ALL, 32'h0);
		wr(5'h18, 32'h1);
		check({30'h0, wresp}, {30'h0, RESP_SLVERR});
		wr(OFF_TXH, 32'h55);
		check({30'h0, wresp}, {30'h0, RESP_OKAY});
		rchk(OFF_STAT, ALL, 32'h84);
		$display("test reset and idle done");
		u_peer.clear();
		wr(OFF_MODE, 32'h1);
		wr(OFF_CTRL, 32'hA4);
		check(sclk_oe_n, 1'b0);
		check(irq_te, 1'b1);
		wr(OFF_TXH, 32'h3C);
		d = 32'h0;
		while (d[7] !== 1'b1)
			rd(OFF_STAT, d, r);
		wr(OFF_TXH, 32'h69);
		while (u_peer.n_rise < 16)
			@(posedge ref_clk);
		cyc(20);
		check(u_peer.got_q[0], 8'h3C);
		check(u_peer.got_q[1], 8'h69);
		check(u_peer.n_rise, 16);
		check(u_peer.max_gap, 400);
		check(sclk_dut, 1'b1);
		check(txd, 1'b0);
		rchk(OFF_STAT, ALL, 32'h84);
		check(irq_tx_end_flag, 1'b1);
		$display("test internal transmit done");
		u_peer.load(8'hA5);
		u_peer.load(8'h0F);
		u_peer.load(8'hC6);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CTRL, 32'h50);
		while (irq_re !== 1'b1)
			@(posedge ref_clk);
		cyc(4);
		rchk(OFF_STAT, 32'hE0, 32'hE0);
		check(irq_rf, 1'b1);
		rchk(OFF_RXH, ALL, 32'hA5);
		rchk(OFF_STAT, 32'hE0, 32'hA0);
		snap = u_peer.n_rise;
		cyc(100);
		check(u_peer.n_rise, snap);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CTRL, 32'h70);
		wr(OFF_TXH, 32'h5A);
		cyc(40);
		rchk(OFF_STAT, 32'hE0, 32'h20);
		wr(OFF_STAT, 32'h0);
		while (irq_rf !== 1'b1)
			@(posedge ref_clk);
		wr(OFF_CTRL, 32'h60);
		check(u_peer.got_q[$], 8'h5A);
		rchk(OFF_STAT, 32'h40, 32'h40);
		rchk(OFF_RXH, ALL, 32'hC6);
		$display("test receive and overrun done");
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CTRL, 32'h22);
		check(sclk_oe_n, 1'b1);
		u_peer.clear();
		wr(OFF_TXH, 32'hC3);
		cyc(10);
		u_peer.ext_frame();
		cyc(20);
		check(u_peer.got_q[0], 8'hC3);
		rchk(OFF_STAT, 32'h84, 32'h84);
		$display("test external clock done");
		finish_test();
	end
endmodule
